// ---- design/otpr_pkg.sv ----
// Constants, types and shared layout for the one-time register access block.
// What this block does and what the host system must do
// RULE_01: Seventeen one-time registers, each lockable on its own.
// RULE_02: First register splits into factory-number half and blank user half; others blank.
// RULE_03: Programmed bits never erase; unlocked registers accept repeated bit programming.
// RULE_04: A programmed lock bit makes its register read-only forever.
// RULE_05: Host enters identifier-read state, then reads 16-bit words at register offsets.
// RULE_06: Host writes program command at register address, then data at that address.
// RULE_07: Device programs user register contents one 16-bit word per operation.
// RULE_08: Program command outside one-time space sets the program error flag.
// RULE_09: Programming a locked register sets program and lock errors, changes nothing.
// RULE_10: Host drives upper address lines high on top-parameter parts.
// RULE_11: Host locks registers by program command plus data with cleared select bits.
// RULE_12: First lock register at offset 0x80, second at 0x89, for read and program.
// RULE_13: Bit 0 of first lock register arrives programmed, locking the factory half.
// RULE_14: Host locks the user half by writing 0xFFFD to the first lock register.
// RULE_15: Each second-lock-register bit locks one of the upper sixteen registers.
// RULE_16: While the reset pin is low the device ignores all control inputs.
// RULE_17: Host holds the reset pin low at least 100 ns.
// RULE_18: Reset during program aborts it and completes within 25 time units.
// RULE_19: Reset with no operation running completes within the minimum pulse width.
// RULE_20: Host holds reset 60 us or 300 us after core supply is valid.
// RULE_21: System drives the memory reset from the processor reset.
// RULE_22: Leaving reset, the device returns to array-read state.
package otpr_pkg;

    // ------------------------------------------------------------------
    // Offsets and layout
    // ------------------------------------------------------------------
    localparam logic [15:0] OTPR_LOCK0_OFS = 16'h0080;
    localparam logic [15:0] OTPR_REG0_OFS = 16'h0081;
    localparam logic [15:0] OTPR_LOCK1_OFS = 16'h0089;
    localparam logic [15:0] OTPR_REGS_OFS = 16'h008A;
    localparam logic [15:0] OTPR_END_OFS = 16'h0109;
    localparam logic [7:0] OTPR_HALF_WORDS = 8'h04;
    localparam logic [7:0] OTPR_WORDS_PER_REG = 8'h08;
    localparam int OTPR_ARRAY_WORDS = 136;
    localparam int OTPR_FACTORY_LOCK_BIT = 0;
    localparam int OTPR_USER_LOCK_BIT = 1;

    // ------------------------------------------------------------------
    // Reset values and commands
    // ------------------------------------------------------------------
    localparam logic [15:0] OTPR_BLANK_WORD = 16'hFFFF;
    localparam logic [15:0] OTPR_LOCK0_INIT = 16'hFFFE;
    localparam logic [15:0] OTPR_LOCK1_INIT = 16'hFFFF;
    localparam logic [7:0] OTPR_CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] OTPR_CMD_READ_ID = 8'h90;
    localparam logic [7:0] OTPR_CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] OTPR_CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] OTPR_CMD_PROG_OTP = 8'hC0;

    // ------------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------------
    localparam int OTPR_SR_READY_BIT = 7;
    localparam int OTPR_SR_PROG_ERR_BIT = 4;
    localparam int OTPR_SR_LOCK_ERR_BIT = 1;
    localparam int OTPR_FLAG_PROG = 0;
    localparam int OTPR_FLAG_LOCK = 1;
    localparam int OTPR_NUM_FLAGS = 2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int OTPR_CLK_MHZ = 250;
    localparam int OTPR_PROG_TIME_NS = 1000;
    localparam int OTPR_PROG_CYCLES = (OTPR_PROG_TIME_NS * OTPR_CLK_MHZ + 999) / 1000;
    localparam int OTPR_RESET_PULSE_MIN_NS = 100;
    localparam int OTPR_RESET_PULSE_MIN_CYCLES = (OTPR_RESET_PULSE_MIN_NS * OTPR_CLK_MHZ) / 1000;
    localparam int OTPR_RESET_ABORT_US = 25;
    localparam int OTPR_RESET_ABORT_CYCLES = OTPR_RESET_ABORT_US * OTPR_CLK_MHZ;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OTPR_ST_ARRAY,
        OTPR_ST_IDENT,
        OTPR_ST_STATUS,
        OTPR_ST_PROG_SETUP,
        OTPR_ST_BUSY
    } otpr_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] data;
    } otpr_bus_req_t;

    typedef struct packed {
        logic ready;
        logic program_error_flag;
        logic lock_error_flag;
    } otpr_status_t;

endpackage

// ---- design/otpr_sticky_flag.sv ----
// Sticky status flag in which a set beats a clear in the same cycle.
`timescale 1ns/100ps
module otpr_sticky_flag
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_set,
    input wire logic i_clr,
    // Flag
    output logic o_flag
);

    logic flag_q;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            flag_q <= 1'b0;
        else if (i_set)
            flag_q <= 1'b1;
        else if (i_clr)
            flag_q <= 1'b0;
    end

    assign o_flag = flag_q;

endmodule

// ---- design/otpr_access.sv ----
// One-time register array with identifier reads, word programming, locking and reset pin.
`timescale 1ns/100ps
module otpr_access
    import otpr_pkg::*;
#(
    // Arbitrary factory number, no meaning beyond being blank-free.
    parameter logic [63:0] OTPR_FACTORY_ID = 64'h5A5A_1234_C3C3_9876,
    parameter int OTPR_ABORT_CYCLES = OTPR_RESET_ABORT_CYCLES
)
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Device reset pin
    input wire logic i_dev_rst_n,
    // Flash bus
    input wire otpr_bus_req_t i_bus,
    input wire logic [15:0] i_array_data,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    // State
    output otpr_status_t o_status,
    output otpr_state_t o_mode
);

    localparam int PROG_DLY = OTPR_PROG_CYCLES + 1;

    // ------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------
    function automatic logic in_otp_space(input logic [15:0] a);
        return (a >= OTPR_LOCK0_OFS) && (a <= OTPR_END_OFS);
    endfunction

    function automatic logic is_lock(input logic [15:0] a);
        return (a == OTPR_LOCK0_OFS) || (a == OTPR_LOCK1_OFS); // RULE_12
    endfunction

    function automatic logic [7:0] word_index(input logic [15:0] a);
        if (a < OTPR_LOCK1_OFS)
            return 8'(a - OTPR_REG0_OFS);
        return 8'(a - OTPR_REGS_OFS + 16'(OTPR_WORDS_PER_REG));
    endfunction

    function automatic logic word_locked(input logic [15:0] a, input logic [15:0] l0,
                                         input logic [15:0] l1);
        logic [7:0] i;
        logic [3:0] k;
        i = word_index(a);
        k = 4'((i - OTPR_WORDS_PER_REG) / OTPR_WORDS_PER_REG);
        if (is_lock(a))
            return 1'b0;
        if (i < OTPR_HALF_WORDS)
            return !l0[OTPR_FACTORY_LOCK_BIT]; // RULE_13
        if (i < OTPR_WORDS_PER_REG)
            return !l0[OTPR_USER_LOCK_BIT];
        return !l1[k]; // RULE_15
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] otp_mem_q [0:OTPR_ARRAY_WORDS-1];
    logic [15:0] lock0_q;
    logic [15:0] lock1_q;
    otpr_state_t state_q;
    logic [15:0] addr_q;
    logic [15:0] data_q;
    logic [8:0] cnt_q;
    logic [7:0] idx_q;
    logic [OTPR_NUM_FLAGS-1:0] flag_set;
    logic [OTPR_NUM_FLAGS-1:0] flag_val;
    logic flag_clr;
    logic read_state;
    logic prog_data_wr;
    logic target_bad;
    logic commit;

    assign read_state = (state_q == OTPR_ST_ARRAY) || (state_q == OTPR_ST_IDENT)
                        || (state_q == OTPR_ST_STATUS);
    // Data write follows the command and is aimed at the latched address.
    assign prog_data_wr = i_dev_rst_n && i_bus.wr && (state_q == OTPR_ST_PROG_SETUP); // RULE_06
    assign target_bad = !in_otp_space(addr_q) || word_locked(addr_q, lock0_q, lock1_q);
    assign commit = i_dev_rst_n && (state_q == OTPR_ST_BUSY) && (cnt_q == 9'h000);
    assign idx_q = word_index(addr_q);

    // ------------------------------------------------------------------
    // Command sequencing
    // ------------------------------------------------------------------
    // The reset pin wins over everything, so a pending program is dropped before commit.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || !i_dev_rst_n)
        begin
            state_q <= OTPR_ST_ARRAY; // RULE_16 RULE_18 RULE_19 RULE_22
            cnt_q <= 9'h000;
        end
        else
        begin
            case (state_q)
                OTPR_ST_ARRAY, OTPR_ST_IDENT, OTPR_ST_STATUS:
                begin
                    if (i_bus.wr)
                    begin
                        case (i_bus.data[7:0])
                            OTPR_CMD_READ_ARRAY: state_q <= OTPR_ST_ARRAY;
                            OTPR_CMD_READ_ID: state_q <= OTPR_ST_IDENT; // RULE_05
                            OTPR_CMD_READ_STATUS: state_q <= OTPR_ST_STATUS;
                            OTPR_CMD_PROG_OTP: state_q <= OTPR_ST_PROG_SETUP;
                            default: state_q <= state_q;
                        endcase
                    end
                end
                OTPR_ST_PROG_SETUP:
                begin
                    if (i_bus.wr)
                    begin
                        if (target_bad)
                            state_q <= OTPR_ST_STATUS; // RULE_04 RULE_09
                        else
                        begin
                            state_q <= OTPR_ST_BUSY;
                            cnt_q <= 9'(OTPR_PROG_CYCLES - 1);
                        end
                    end
                end
                OTPR_ST_BUSY:
                begin
                    if (cnt_q == 9'h000)
                        state_q <= OTPR_ST_STATUS;
                    else
                        cnt_q <= cnt_q - 9'h001;
                end
                default: state_q <= OTPR_ST_ARRAY;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            addr_q <= 16'h0000;
            data_q <= 16'h0000;
        end
        else if (i_dev_rst_n && i_bus.wr && read_state
                 && (i_bus.data[7:0] == OTPR_CMD_PROG_OTP))
            addr_q <= i_bus.addr;
        else if (prog_data_wr)
            data_q <= i_bus.data;
    end

    // ------------------------------------------------------------------
    // One-time storage
    // ------------------------------------------------------------------
    // Only the logic reset loads the array; the reset pin leaves stored bits alone.
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            // Two loops, so no select ever reaches past the end of the factory number.
            for (int i = 0; i < OTPR_ARRAY_WORDS; i++) // RULE_01
                otp_mem_q[i] <= OTPR_BLANK_WORD; // RULE_02
            for (int i = 0; i < int'(OTPR_HALF_WORDS); i++)
                otp_mem_q[i] <= OTPR_FACTORY_ID[16*i +: 16]; // RULE_02
            lock0_q <= OTPR_LOCK0_INIT; // RULE_13
            lock1_q <= OTPR_LOCK1_INIT;
        end
        else if (commit)
        begin
            // Programming can only clear bits, so an AND models the cells.
            if (addr_q == OTPR_LOCK0_OFS)
                lock0_q <= lock0_q & data_q; // RULE_04 RULE_12
            else if (addr_q == OTPR_LOCK1_OFS)
                lock1_q <= lock1_q & data_q; // RULE_15
            else
                otp_mem_q[idx_q] <= otp_mem_q[idx_q] & data_q; // RULE_03 RULE_07
        end
    end

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    assign flag_set[OTPR_FLAG_PROG] = prog_data_wr && target_bad; // RULE_08 RULE_09
    assign flag_set[OTPR_FLAG_LOCK] = prog_data_wr && in_otp_space(addr_q)
                                      && word_locked(addr_q, lock0_q, lock1_q); // RULE_09
    assign flag_clr = !i_dev_rst_n || (i_bus.wr && read_state
                      && (i_bus.data[7:0] == OTPR_CMD_CLEAR_STATUS));

    genvar g;
    generate
        for (g = 0; g < OTPR_NUM_FLAGS; g++)
        begin : g_flag
            otpr_sticky_flag u_flag (
                .i_ref_clk(i_ref_clk),
                .i_rst(i_rst),
                .i_set(flag_set[g]),
                .i_clr(flag_clr),
                .o_flag(flag_val[g])
            );
        end
    endgenerate

    assign o_status.ready = (state_q != OTPR_ST_BUSY);
    assign o_status.program_error_flag = flag_val[OTPR_FLAG_PROG];
    assign o_status.lock_error_flag = flag_val[OTPR_FLAG_LOCK];
    assign o_mode = state_q;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || !i_dev_rst_n)
        begin
            o_rdata <= 16'h0000; // RULE_16
            o_rvalid <= 1'b0;
        end
        else
        begin
            o_rvalid <= i_bus.rd;
            if (i_bus.rd)
            begin
                case (state_q)
                    OTPR_ST_ARRAY: o_rdata <= i_array_data; // RULE_22
                    OTPR_ST_IDENT:
                    begin
                        if (i_bus.addr == OTPR_LOCK0_OFS)
                            o_rdata <= lock0_q; // RULE_12
                        else if (i_bus.addr == OTPR_LOCK1_OFS)
                            o_rdata <= lock1_q; // RULE_12
                        else if (in_otp_space(i_bus.addr))
                            o_rdata <= otp_mem_q[word_index(i_bus.addr)]; // RULE_05
                        else
                            o_rdata <= 16'h0000;
                    end
                    default:
                    begin
                        o_rdata <= 16'h0000;
                        o_rdata[OTPR_SR_READY_BIT] <= (state_q != OTPR_ST_BUSY);
                        o_rdata[OTPR_SR_PROG_ERR_BIT] <= flag_val[OTPR_FLAG_PROG];
                        o_rdata[OTPR_SR_LOCK_ERR_BIT] <= flag_val[OTPR_FLAG_LOCK];
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    a_reset_to_array: assert property (!i_dev_rst_n |=> state_q == OTPR_ST_ARRAY) // RULE_22
        else $error("reset pin did not return to array read");
    a_reset_ignores: assert property (!i_dev_rst_n && i_bus.wr |=> !o_rvalid
        && flag_val == 2'b00) // RULE_16
        else $error("command acted on while reset pin low");
    a_reset_abort: assert property ((state_q == OTPR_ST_BUSY) && !i_dev_rst_n
        |=> (otp_mem_q[idx_q] == $past(otp_mem_q[idx_q])) && state_q == OTPR_ST_ARRAY) // RULE_18
        else $error("program not aborted by reset pin");
    a_idle_reset: assert property ((state_q != OTPR_ST_BUSY) && !i_dev_rst_n
        |=> !o_rvalid && o_rdata == 16'h0000) // RULE_19
        else $error("idle reset not complete in time");
    a_bits_only_clear: assert property (commit && !is_lock(addr_q)
        |=> (otp_mem_q[idx_q] & ~$past(otp_mem_q[idx_q])) == 16'h0000) // RULE_03
        else $error("programmed bit returned to erased");
    a_word_program: assert property (commit && !is_lock(addr_q)
        |=> otp_mem_q[idx_q] == ($past(otp_mem_q[idx_q]) & $past(data_q))) // RULE_07
        else $error("word program result wrong");
    a_outside_error: assert property (prog_data_wr && !in_otp_space(addr_q)
        |=> o_status.program_error_flag && state_q == OTPR_ST_STATUS) // RULE_08
        else $error("outside program did not flag error");
    a_locked_error: assert property (prog_data_wr && in_otp_space(addr_q)
        && word_locked(addr_q, lock0_q, lock1_q)
        |=> o_status.program_error_flag && o_status.lock_error_flag
        && state_q != OTPR_ST_BUSY) // RULE_09
        else $error("locked program not refused");
    a_factory_lock: assert property (lock0_q[OTPR_FACTORY_LOCK_BIT] == 1'b0) // RULE_13
        else $error("factory lock bit not programmed");
    a_lock_map: assert property (commit && !is_lock(addr_q) && idx_q >= OTPR_WORDS_PER_REG
        |-> lock1_q[4'((idx_q - OTPR_WORDS_PER_REG) / OTPR_WORDS_PER_REG)]) // RULE_15
        else $error("locked upper register was programmed");
    a_lock_sticky: assert property (lock0_q[OTPR_USER_LOCK_BIT] == 1'b0
        |=> lock0_q[OTPR_USER_LOCK_BIT] == 1'b0) // RULE_04
        else $error("lock bit was undone");
    a_prog_time: assert property (prog_data_wr && !target_bad
        |-> ##PROG_DLY (state_q == OTPR_ST_STATUS || state_q == OTPR_ST_ARRAY)) // RULE_07
        else $error("program did not finish on time");

    c_commit: cover property (commit);
    c_lock_error: cover property (flag_set[OTPR_FLAG_LOCK]);
    c_abort: cover property ((state_q == OTPR_ST_BUSY) && !i_dev_rst_n);
    c_ident_read: cover property (i_bus.rd && state_q == OTPR_ST_IDENT);

endmodule

// ---- bench/otpr_host_model.sv ----
// Host-side model that issues flash bus cycles and drives the device reset pin.
`timescale 1ns/100ps
module otpr_host_model
    import otpr_pkg::*;
(
    // Clock
    input wire logic i_ref_clk,
    // Flash bus
    output otpr_bus_req_t o_bus,
    output logic [15:0] o_array_data,
    input wire logic [15:0] i_rdata,
    input wire logic i_rvalid,
    // Device reset pin
    output logic o_dev_rst_n
);
    // ------------------------------------------------------------------
    // Idle levels and main array contents
    // ------------------------------------------------------------------
    // The pin starts low with the processor reset so no stale status is read.
    initial
    begin
        o_bus = '0;
        o_dev_rst_n = 1'b0;
    end

    // Address-dependent array pattern so a wrong read source shows up.
    assign o_array_data = {o_bus.addr[7:0], ~o_bus.addr[7:0]};

    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    // Offsets are already base-relative; upper address lines are not modelled.
    // Released lines show the inverse value so a late sample cannot match.
    task automatic bus_write(input logic [15:0] addr, input logic [15:0] data);
        @(negedge i_ref_clk);
        o_bus.wr = 1'b1;
        o_bus.addr = addr;
        o_bus.data = data;
        @(negedge i_ref_clk);
        o_bus.wr = 1'b0;
        o_bus.addr = ~addr;
        o_bus.data = ~data;
    endtask

    task automatic bus_read(input logic [15:0] addr, output logic [15:0] data, output logic ok);
        @(negedge i_ref_clk);
        o_bus.rd = 1'b1;
        o_bus.addr = addr;
        @(negedge i_ref_clk);
        ok = i_rvalid;
        data = i_rdata;
        o_bus.rd = 1'b0;
        o_bus.addr = ~addr;
    endtask

    // Low time of the pin is the caller's business; at least 25 cycles for a sure reset.
    task automatic set_rst_pin(input logic level);
        @(negedge i_ref_clk);
        o_dev_rst_n = level;
    endtask
endmodule

// ---- bench/otp_register_access_and_reset_test.sv ----
// Self-checking testbench for the one-time register access block.
`timescale 1ns/100ps
module otp_register_access_and_reset_test
    import otpr_pkg::*;
();
    // Arbitrary factory number.
    localparam logic [63:0] FACTORY_NUM = 64'h0123_4567_89AB_CDEF;

    logic i_ref_clk;
    logic i_rst;
    otpr_bus_req_t bus;
    logic dev_rst_n;
    logic [15:0] array_data;
    logic [15:0] rdata;
    logic rvalid;
    otpr_status_t status;
    otpr_state_t mode;
    int n_checks = 0;
    int miscompares = 0;

    otpr_access #(.OTPR_FACTORY_ID(FACTORY_NUM)) dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_dev_rst_n(dev_rst_n), .i_bus(bus), .i_array_data(array_data), .o_rdata(rdata),
        .o_rvalid(rvalid), .o_status(status), .o_mode(mode));

    otpr_host_model host_u (.i_ref_clk(i_ref_clk), .o_bus(bus), .o_array_data(array_data),
        .i_rdata(rdata), .i_rvalid(rvalid), .o_dev_rst_n(dev_rst_n));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        n_checks++;
        if (seen !== expected)
        begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expected);
        end
    endtask

    task automatic wait_mode(input otpr_state_t target);
        int n;
        n = 0;
        while (mode !== target && n < 400)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        if (mode !== target)
        begin
            miscompares++;
            $display("[FAIL] t=%0t mode=%h expected=%h", $time, mode, target);
            finish_test();
        end
    endtask

    task automatic check_status(input logic [2:0] exp);
        check({13'h0000, status}, {13'h0000, exp});
    endtask

    task automatic command(input logic [7:0] cmd);
        host_u.bus_write(16'h0ABC, {8'h00, cmd});
    endtask

    task automatic read_id(input logic [15:0] addr, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host_u.bus_read(addr, d, ok);
        check({15'h0000, ok}, 16'h0001);
        check(d, exp);
    endtask

    // Program one word and land in identifier-read state for the readback.
    task automatic prog(input logic [15:0] addr, input logic [15:0] data, input logic [2:0] exp);
        host_u.bus_write(addr, {8'h00, OTPR_CMD_PROG_OTP});
        host_u.bus_write(addr, data);
        wait_mode(OTPR_ST_STATUS);
        check_status(exp);
        command(OTPR_CMD_CLEAR_STATUS);
        command(OTPR_CMD_READ_ID);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_state();
        check({13'h0000, mode}, {13'h0000, OTPR_ST_ARRAY});
        check_status(3'b100);
        read_id(16'h0123, 16'h23DC);
        command(OTPR_CMD_READ_STATUS);
        read_id(16'h0012, 16'h0080);
        command(OTPR_CMD_READ_ARRAY);
        read_id(16'h0012, 16'h12ED);
    endtask

    task automatic test_ident_map();
        command(OTPR_CMD_READ_ID);
        check({13'h0000, mode}, {13'h0000, OTPR_ST_IDENT});
        read_id(16'h0080, 16'hFFFE);
        read_id(16'h0089, 16'hFFFF);
        for (int w = 0; w < 4; w++)
            read_id(16'h0081 + w[15:0], FACTORY_NUM[16*w +: 16]);
        read_id(16'h0085, 16'hFFFF);
        read_id(16'h0109, 16'hFFFF);
    endtask

    task automatic test_program();
        host_u.bus_write(16'h0085, {8'h00, OTPR_CMD_PROG_OTP});
        host_u.bus_write(16'h0085, 16'h1234);
        wait_mode(OTPR_ST_BUSY);
        check({15'h0000, status.ready}, 16'h0000);
        wait_mode(OTPR_ST_STATUS);
        check_status(3'b100);
        command(OTPR_CMD_READ_ID);
        read_id(16'h0085, 16'h1234);
        prog(16'h0085, 16'hFF0F, 3'b100);
        read_id(16'h0085, 16'h1204);
    endtask

    task automatic test_errors();
        logic [15:0] d;
        logic ok;
        prog(16'h0081, 16'h0000, 3'b111);
        read_id(16'h0081, FACTORY_NUM[15:0]);
        host_u.bus_write(16'h0200, {8'h00, OTPR_CMD_PROG_OTP});
        host_u.bus_write(16'h0200, 16'h0000);
        wait_mode(OTPR_ST_STATUS);
        host_u.bus_read(16'h0000, d, ok);
        check(d & 16'h0092, 16'h0090);
        command(OTPR_CMD_CLEAR_STATUS);
        check_status(3'b100);
    endtask

    task automatic test_locks();
        prog(16'h0080, 16'hFFFD, 3'b100);
        read_id(16'h0080, 16'hFFFC);
        prog(16'h0088, 16'h0000, 3'b111);
        read_id(16'h0088, 16'hFFFF);
        prog(16'h0089, 16'h7FFE, 3'b100);
        read_id(16'h0089, 16'h7FFE);
        prog(16'h0091, 16'h0000, 3'b111);
        prog(16'h0109, 16'h0000, 3'b111);
        prog(16'h0092, 16'h00FF, 3'b100);
        read_id(16'h0092, 16'h00FF);
    endtask

    task automatic test_reset_pin();
        // The user half of register zero is locked by now; register two is still open.
        host_u.bus_write(16'h0093, {8'h00, OTPR_CMD_PROG_OTP});
        host_u.bus_write(16'h0093, 16'h0000);
        wait_mode(OTPR_ST_BUSY);
        host_u.set_rst_pin(1'b0);
        @(negedge i_ref_clk);
        check({13'h0000, mode}, {13'h0000, OTPR_ST_ARRAY});
        check_status(3'b100);
        command(OTPR_CMD_READ_ID);
        check({13'h0000, mode}, {13'h0000, OTPR_ST_ARRAY});
        repeat (22) @(negedge i_ref_clk);
        host_u.set_rst_pin(1'b1);
        command(OTPR_CMD_READ_ID);
        read_id(16'h0093, 16'hFFFF);
        host_u.set_rst_pin(1'b0);
        @(negedge i_ref_clk);
        check({13'h0000, mode}, {13'h0000, OTPR_ST_ARRAY});
        repeat (24) @(negedge i_ref_clk);
        host_u.set_rst_pin(1'b1);
        read_id(16'h0044, 16'h44BB);
    endtask

    // ------------------------------------------------------------------
    // Clock, reset and main sequence
    // ------------------------------------------------------------------
    initial
    begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    initial
    begin
        i_rst = 1'b1;
        repeat (20) @(negedge i_ref_clk);
        i_rst = 1'b0;
        host_u.set_rst_pin(1'b1);
        test_reset_state();
        test_ident_map();
        test_program();
        test_errors();
        test_locks();
        test_reset_pin();
        finish_test();
    end
endmodule
